// file: core/excl_pkg.sv
package excl_pkg;

	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int ADDR_W = 32;
	localparam int DATA_W = 32;
	localparam int REG_IDX_W = 4;
	localparam int OFFSET_W = 10;

	// ----------------------------------------
	// Status values and reset values
	// ----------------------------------------
	localparam logic [DATA_W-1:0] STATUS_DONE = 32'h0000_0000;
	localparam logic [DATA_W-1:0] STATUS_FAIL = 32'h0000_0001;
	localparam logic [DATA_W-1:0] DATA_RESET = 32'h0000_0000;
	localparam logic [ADDR_W-1:0] ADDR_RESET = 32'h0000_0000;
	localparam logic [REG_IDX_W-1:0] IDX_RESET = 4'h0;

	// ----------------------------------------
	// Monitor granule: word address bits
	// ----------------------------------------
	localparam int GRANULE_LSB = 2;

	typedef enum logic [1:0] {OP_LOAD, OP_STORE, OP_CLEAR} op_t;
	typedef enum logic [1:0] {SZ_BYTE, SZ_HALF, SZ_WORD} size_t;

	typedef struct packed {
		op_t op;
		size_t size;
		logic [ADDR_W-1:0] base_addr_reg;
		logic offset_en;
		logic [OFFSET_W-1:0] offset;
		logic [REG_IDX_W-1:0] data_reg;
		logic [REG_IDX_W-1:0] status_reg;
		logic [DATA_W-1:0] wdata;
	} cmd_t;

	typedef struct packed {
		logic valid;
		logic write;
		size_t size;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} mem_req_t;

	typedef struct packed {
		logic valid;
		logic [REG_IDX_W-1:0] idx;
		logic [DATA_W-1:0] data;
	} reg_wr_t;

endpackage

// file: core/excl_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module excl_monitor
(
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	// Arm and clear
	input wire logic arm_in,
	input wire logic clear_in,
	input wire logic [excl_pkg::ADDR_W-1:0] arm_addr_in,
	input wire excl_pkg::size_t arm_size_in,
	// Other agents
	input wire logic snoop_valid_in,
	input wire logic [excl_pkg::ADDR_W-1:0] snoop_addr_in,
	// Check
	input wire logic [excl_pkg::ADDR_W-1:0] chk_addr_in,
	input wire excl_pkg::size_t chk_size_in,
	output logic pass_out,
	output logic excl_out
);

	typedef enum logic {MON_OPEN, MON_EXCL} mon_state_t;

	mon_state_t st_q, st_d;
	logic [excl_pkg::ADDR_W-1:0] addr_q, addr_d;
	excl_pkg::size_t size_q, size_d;
	logic snoop_hit;

	// ----------------------------------------
	// Tracking
	// ----------------------------------------
	// Word granule: a neighbour byte write also breaks the reservation, which is safe
	assign snoop_hit = snoop_valid_in &&
		(snoop_addr_in[excl_pkg::ADDR_W-1:excl_pkg::GRANULE_LSB] ==
		addr_q[excl_pkg::ADDR_W-1:excl_pkg::GRANULE_LSB]);

	always_comb
	begin
		st_d = st_q;
		addr_d = addr_q;
		size_d = size_q;
		if (arm_in)
		begin
			st_d = MON_EXCL;
			addr_d = arm_addr_in;
			size_d = arm_size_in;
		end
		// Clear and foreign access win over arming, erring toward failure
		if (clear_in || snoop_hit)
			st_d = MON_OPEN;
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (!nrst_in)
		begin
			st_q <= MON_OPEN;
			addr_q <= excl_pkg::ADDR_RESET;
			size_q <= excl_pkg::SZ_WORD;
		end
		else
		begin
			st_q <= st_d;
			addr_q <= addr_d;
			size_q <= size_d;
		end
	end

	// Access in the same cycle as the check still counts as interference
	assign pass_out = (st_q == MON_EXCL) && (chk_addr_in == addr_q) &&
		(chk_size_in == size_q) && !snoop_hit;
	assign excl_out = (st_q == MON_EXCL);

endmodule
`default_nettype wire

// file: core/exclusive_access_monitor.sv
// Behaviour
// - Exclusive load returns sized value to data_reg
// - Exclusive store writes only if monitor allows
// - Address is base plus optional offset, offset for word size only
// - Committed store writes status zero
// - Failed store skips memory, writes status one
// - Success only without foreign access between
// - Clear makes next store fail
// - Condition flags never changed
`timescale 1ns/1ps
`default_nettype none
module exclusive_access_monitor
(
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	// Command from the pipeline
	input wire logic cmd_valid_in,
	input wire excl_pkg::cmd_t cmd_in,
	output logic cmd_ready_out,
	// Memory port
	output excl_pkg::mem_req_t mem_req_out,
	input wire logic mem_ack_in,
	input wire logic [excl_pkg::DATA_W-1:0] mem_rdata_in,
	// Accesses by other agents
	input wire logic snoop_valid_in,
	input wire logic [excl_pkg::ADDR_W-1:0] snoop_addr_in,
	// Register file write-back
	output excl_pkg::reg_wr_t reg_wr_out,
	output logic flags_we_out
);

	typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_STORE} state_t;

	state_t st_q, st_d;
	logic ready_q, ready_d;
	excl_pkg::mem_req_t mem_q, mem_d;
	excl_pkg::reg_wr_t wr_q, wr_d;
	excl_pkg::size_t size_q, size_d;
	logic [excl_pkg::REG_IDX_W-1:0] idx_q, idx_d;
	logic flags_we_q, flags_we_d;

	logic accept;
	logic [excl_pkg::ADDR_W-1:0] eff_addr;
	logic [excl_pkg::DATA_W-1:0] load_ext;
	logic mon_arm;
	logic mon_clear;
	logic mon_pass;
	logic mon_excl;

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	assign accept = cmd_valid_in && ready_q;

	// Byte and halfword forms carry no offset
	assign eff_addr = (cmd_in.offset_en && cmd_in.size == excl_pkg::SZ_WORD) ?
		cmd_in.base_addr_reg + excl_pkg::ADDR_W'(cmd_in.offset) :
		cmd_in.base_addr_reg;

	// Memory returns the addressed item in the low lanes; narrow loads zero extend
	always_comb
	begin
		unique case (size_q)
			excl_pkg::SZ_BYTE: load_ext = {24'h00_0000, mem_rdata_in[7:0]};
			excl_pkg::SZ_HALF: load_ext = {16'h0000, mem_rdata_in[15:0]};
			excl_pkg::SZ_WORD: load_ext = mem_rdata_in;
			default: load_ext = mem_rdata_in;
		endcase
	end

	assign mon_arm = accept && cmd_in.op == excl_pkg::OP_LOAD;
	assign mon_clear = accept && (cmd_in.op == excl_pkg::OP_CLEAR ||
		cmd_in.op == excl_pkg::OP_STORE);

	excl_monitor u_monitor
	(
		.clk_sys_in(clk_sys_in),
		.nrst_in(nrst_in),
		.arm_in(mon_arm),
		.clear_in(mon_clear),
		.arm_addr_in(eff_addr),
		.arm_size_in(cmd_in.size),
		.snoop_valid_in(snoop_valid_in),
		.snoop_addr_in(snoop_addr_in),
		.chk_addr_in(eff_addr),
		.chk_size_in(cmd_in.size),
		.pass_out(mon_pass),
		.excl_out(mon_excl)
	);

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_comb
	begin
		st_d = st_q;
		ready_d = ready_q;
		mem_d = mem_q;
		wr_d = wr_q;
		wr_d.valid = 1'b0;
		size_d = size_q;
		idx_d = idx_q;
		// None of these operations touch the condition flags
		flags_we_d = 1'b0;
		unique case (st_q)
			ST_IDLE:
			begin
				// Ready rises one edge after reset release
				if (!accept)
					ready_d = 1'b1;
				if (accept)
				begin
					unique case (cmd_in.op)
						excl_pkg::OP_LOAD:
						begin
							mem_d = '{1'b1, 1'b0, cmd_in.size, eff_addr, excl_pkg::DATA_RESET};
							size_d = cmd_in.size;
							idx_d = cmd_in.data_reg;
							ready_d = 1'b0;
							st_d = ST_LOAD;
						end
						excl_pkg::OP_STORE:
						begin
							if (mon_pass)
							begin
								mem_d = '{1'b1, 1'b1, cmd_in.size, eff_addr, cmd_in.wdata};
								idx_d = cmd_in.status_reg;
								ready_d = 1'b0;
								st_d = ST_STORE;
							end
							else
							begin
								// No memory cycle at all on failure
								wr_d = '{1'b1, cmd_in.status_reg, excl_pkg::STATUS_FAIL};
							end
						end
						default:
						begin
						end
					endcase
				end
			end
			ST_LOAD:
			begin
				if (mem_ack_in)
				begin
					mem_d.valid = 1'b0;
					wr_d = '{1'b1, idx_q, load_ext};
					ready_d = 1'b1;
					st_d = ST_IDLE;
				end
			end
			ST_STORE:
			begin
				if (mem_ack_in)
				begin
					mem_d.valid = 1'b0;
					wr_d = '{1'b1, idx_q, excl_pkg::STATUS_DONE};
					ready_d = 1'b1;
					st_d = ST_IDLE;
				end
			end
			default:
			begin
				st_d = ST_IDLE;
				ready_d = 1'b1;
				mem_d.valid = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (!nrst_in)
		begin
			st_q <= ST_IDLE;
			ready_q <= 1'b0;
			mem_q <= '{1'b0, 1'b0, excl_pkg::SZ_WORD, excl_pkg::ADDR_RESET, excl_pkg::DATA_RESET};
			wr_q <= '{1'b0, excl_pkg::IDX_RESET, excl_pkg::DATA_RESET};
			size_q <= excl_pkg::SZ_WORD;
			idx_q <= excl_pkg::IDX_RESET;
			flags_we_q <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
			ready_q <= ready_d;
			mem_q <= mem_d;
			wr_q <= wr_d;
			size_q <= size_d;
			idx_q <= idx_d;
			flags_we_q <= flags_we_d;
		end
	end

	assign cmd_ready_out = ready_q;
	assign mem_req_out = mem_q;
	assign reg_wr_out = wr_q;
	assign flags_we_out = flags_we_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_load_taken;
		accept && cmd_in.op == excl_pkg::OP_LOAD;
	endsequence

	sequence s_store_taken;
		accept && cmd_in.op == excl_pkg::OP_STORE;
	endsequence

	sequence s_store_acked;
		st_q == ST_STORE && mem_ack_in;
	endsequence

	a_load_data_back: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
		st_q == ST_LOAD && mem_ack_in |=> reg_wr_out.valid && reg_wr_out.idx == $past(idx_q) &&
		reg_wr_out.data == $past(load_ext))
		else $error("load data not returned");

	a_store_write_gated: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
		s_store_taken |=> (mem_req_out.valid && mem_req_out.write) == $past(mon_pass))
		else $error("store write not gated by monitor");

	a_addr_offset: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
		s_load_taken ##0 (cmd_in.size != excl_pkg::SZ_WORD || !cmd_in.offset_en)
		|=> mem_req_out.addr == $past(cmd_in.base_addr_reg))
		else $error("address without offset wrong");

	a_store_ok_status: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
		s_store_acked |=> reg_wr_out.valid && reg_wr_out.data == excl_pkg::STATUS_DONE ##1 !reg_wr_out.valid)
		else $error("committed store status not zero");

	a_store_fail_status: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
		s_store_taken ##0 !mon_pass |=> reg_wr_out.valid && reg_wr_out.data == excl_pkg::STATUS_FAIL &&
		!mem_req_out.valid)
		else $error("failed store status or write wrong");

	a_snoop_breaks: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
		mon_excl && snoop_valid_in &&
		snoop_addr_in[excl_pkg::ADDR_W-1:excl_pkg::GRANULE_LSB] ==
		mem_req_out.addr[excl_pkg::ADDR_W-1:excl_pkg::GRANULE_LSB]
		|=> !mon_excl)
		else $error("reservation kept after foreign access");

	a_clear_fails: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
		accept && cmd_in.op == excl_pkg::OP_CLEAR |=> !mon_excl)
		else $error("clear left monitor exclusive");

	a_flags_kept: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
		accept |-> ##[1:3] !flags_we_out)
		else $error("condition flags written");

	a_reopen_store: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
		s_store_taken |=> !mon_excl)
		else $error("monitor not open after store");

endmodule
`default_nettype wire

// file: test/mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module mem_model
(
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	// Memory port
	input wire excl_pkg::mem_req_t req_in,
	output logic ack_out,
	output logic [31:0] rdata_out
);
	logic [31:0] store [logic [31:0]];
	int wait_q = 0;
	function automatic logic [31:0] msk(input excl_pkg::size_t s);
		return s == excl_pkg::SZ_BYTE ? 32'h0000_00ff : s == excl_pkg::SZ_HALF ? 32'h0000_ffff : 32'hffff_ffff;
	endfunction
	initial ack_out = 1'b0;
	initial rdata_out = 32'h5a5a_5a5a;
	// ----------------------------------------
	// Slow or prompt answer
	// ----------------------------------------
	// Idle read lanes toggle so stale data never looks valid
	always @(posedge clk_sys_in)
	begin
		ack_out <= 1'b0;
		rdata_out <= ~rdata_out;
		if (req_in.valid && !ack_out && nrst_in)
		begin
			if (wait_q == 0)
			begin
				ack_out <= 1'b1;
				wait_q <= $urandom_range(3);
				if (req_in.write)
					store[req_in.addr] = req_in.wdata & msk(req_in.size);
				else
					rdata_out <= (store.exists(req_in.addr) ? store[req_in.addr] : 32'h0) & msk(req_in.size) | ~msk(req_in.size) & $urandom;
			end
			else
				wait_q <= wait_q - 1;
		end
	end
endmodule
`default_nettype wire

// file: test/exclusive_access_monitor_tb.sv
`timescale 1ns/1ps
`default_nettype none
module exclusive_access_monitor_tb;
	logic clk_sys_in = 1'b0;
	logic nrst_in;
	logic cmd_valid_in;
	excl_pkg::cmd_t cmd;
	logic cmd_ready_out;
	excl_pkg::mem_req_t mem_req_out;
	logic mem_ack_in;
	logic [31:0] mem_rdata_in;
	logic snoop_valid_in;
	logic [31:0] snoop_addr_in;
	excl_pkg::reg_wr_t reg_wr_out;
	logic flags_we_out;
	logic [31:0] ex [logic [31:0]];
	logic [31:0] a;
	logic [31:0] wd;
	excl_pkg::size_t s;
	int v;
	int cyc = 0;
	int miscompares = 0;
	int samples_checked = 0;
	always #50 clk_sys_in = ~clk_sys_in;
	exclusive_access_monitor dut (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .cmd_valid_in(cmd_valid_in),
		.cmd_in(cmd), .cmd_ready_out(cmd_ready_out), .mem_req_out(mem_req_out), .mem_ack_in(mem_ack_in),
		.mem_rdata_in(mem_rdata_in), .snoop_valid_in(snoop_valid_in), .snoop_addr_in(snoop_addr_in),
		.reg_wr_out(reg_wr_out), .flags_we_out(flags_we_out));
	mem_model mem (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .req_in(mem_req_out), .ack_out(mem_ack_in),
		.rdata_out(mem_rdata_in));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] sz_mask(input excl_pkg::size_t z);
		return z == excl_pkg::SZ_BYTE ? 32'h0000_00ff : z == excl_pkg::SZ_HALF ? 32'h0000_ffff : 32'hffff_ffff;
	endfunction
	function automatic logic [31:0] peek(input logic [31:0] k, input excl_pkg::size_t z);
		return ex.exists(k) ? ex[k] & sz_mask(z) : 32'h0;
	endfunction
	task automatic check(input logic ok, input string m);
		samples_checked++;
		if (!ok)
		begin
			miscompares++;
			$display("CHECK FAILED at %0t: %s", $time, m);
		end
	endtask
	task automatic stop_test();
		$display("Counts: %0d checked, %0d miscompares", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Word offsets reach 0 to 1020; other sizes carry a stray offset field with its enable low
	task automatic run(input excl_pkg::op_t o, input logic [31:0] exp);
		logic [9:0] off;
		int i;
		@(posedge clk_sys_in);
		#1;
		off = (s == excl_pkg::SZ_WORD) ? 10'($urandom_range(255) * 4) : 10'($urandom);
		cmd.op = o;
		cmd.size = s;
		cmd.offset_en = (s == excl_pkg::SZ_WORD) ? 1'($urandom) : 1'b0;
		cmd.offset = off;
		cmd.base_addr_reg = a - ((s == excl_pkg::SZ_WORD && cmd.offset_en) ? 32'(off) : 32'h0);
		cmd.data_reg = 4'($urandom_range(11));
		cmd.status_reg = cmd.data_reg + 4'h1;
		cmd.wdata = wd;
		cmd_valid_in = 1'b1;
		for (i = 0; i < 50 && cmd_ready_out !== 1'b1; i++)
		begin
			@(posedge clk_sys_in);
			#1;
		end
		@(posedge clk_sys_in);
		#1;
		cmd_valid_in = 1'b0;
		if (o == excl_pkg::OP_CLEAR)
			return;
		for (i = 0; i < 20 && reg_wr_out.valid !== 1'b1; i++)
		begin
			@(posedge clk_sys_in);
			#1;
		end
		check(reg_wr_out.valid === 1'b1 && reg_wr_out.data === exp, "write-back value");
		check(reg_wr_out.idx === (o == excl_pkg::OP_LOAD ? cmd.data_reg : cmd.status_reg), "write-back index");
	endtask
	always @(negedge clk_sys_in)
		check(flags_we_out === 1'b0, "flag write");
	// Plenty for 60 rounds of about 25 cycles each
	always @(posedge clk_sys_in)
	begin
		cyc++;
		if (cyc == 10000)
		begin
			miscompares++;
			stop_test();
		end
	end
	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial
	begin
		nrst_in = 1'b0;
		cmd_valid_in = 1'b0;
		cmd = '0;
		snoop_valid_in = 1'b0;
		snoop_addr_in = 32'h0;
		wd = 32'h0;
		void'($urandom(32'h038a2346));
		repeat (3) @(posedge clk_sys_in);
		#1;
		check(cmd_ready_out === 1'b0 && mem_req_out.valid === 1'b0 && reg_wr_out.valid === 1'b0, "reset outputs");
		nrst_in = 1'b1;
		s = excl_pkg::SZ_WORD;
		a = 32'h0000_0100;
		run(excl_pkg::OP_STORE, excl_pkg::STATUS_FAIL);
		$display("Test reset done");
		repeat (60)
		begin
			s = excl_pkg::size_t'($urandom_range(2));
			a = {12'h0, 20'($urandom)} & ~(sz_mask(s) >> 30 | sz_mask(s) >> 31 & 32'h1);
			run(excl_pkg::OP_LOAD, peek(a, s));
			wd = $urandom;
			run(excl_pkg::OP_STORE, excl_pkg::STATUS_DONE);
			ex[a] = wd & sz_mask(s);
			check(mem.store[a] === ex[a], "stored value");
			run(excl_pkg::OP_LOAD, ex[a]);
			v = $urandom_range(3);
			if (v == 1 || v == 2)
			begin
				snoop_valid_in = 1'b1;
				snoop_addr_in = v == 1 ? {a[31:2], 2'($urandom)} : a ^ 32'h4;
				@(posedge clk_sys_in);
				#1;
				snoop_valid_in = 1'b0;
			end
			if (v == 3)
				run(excl_pkg::OP_CLEAR, 32'h0);
			wd = ~wd;
			run(excl_pkg::OP_STORE, (v == 1 || v == 3) ? excl_pkg::STATUS_FAIL : excl_pkg::STATUS_DONE);
			if (v == 0 || v == 2)
				ex[a] = wd & sz_mask(s);
			check(mem.store[a] === ex[a], "memory after store");
			run(excl_pkg::OP_STORE, excl_pkg::STATUS_FAIL);
			check(mem.store[a] === ex[a], "memory after open store");
		end
		$display("Test random pairs done");
		// Reset between load and store must drop the reservation
		run(excl_pkg::OP_LOAD, peek(a, s));
		nrst_in = 1'b0;
		repeat (2) @(posedge clk_sys_in);
		#1;
		check(cmd_ready_out === 1'b0 && mem_req_out.valid === 1'b0 && reg_wr_out.valid === 1'b0, "mid-run reset outputs");
		nrst_in = 1'b1;
		run(excl_pkg::OP_STORE, excl_pkg::STATUS_FAIL);
		check(mem.store[a] === ex[a], "memory after reset store");
		$display("Test reset mid-run done");
		stop_test();
	end
endmodule
`default_nettype wire
